//--- servo_link_pkg.sv
// constants for the addressed ascii serial master (8e1 framing, control codes, timing)
// assumes a 25 MHz mclk; long waits are overridable at the top module
package servo_link_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD = 9600;
  localparam logic [11:0] BAUD_DIV = 12'(CLK_HZ / BAUD);
  // first data-bit sample sits one and a half bit times after the start edge
  localparam logic [11:0] RX_FIRST = 12'(CLK_HZ / BAUD + CLK_HZ / BAUD / 2);
  localparam logic [3:0] TX_BITS = 4'ha;
  localparam logic [3:0] RX_BITS = 4'h9;

  localparam int REPLY_MS = 300;
  localparam int RESEND_MS = 100;
  localparam int START_MS = 3500;
  localparam int REPLY_CYC = CLK_HZ / 1000 * REPLY_MS;
  localparam int RESEND_CYC = CLK_HZ / 1000 * RESEND_MS;
  localparam int START_CYC = CLK_HZ / 1000 * START_MS;

  localparam logic [7:0] SOH = 8'h01;
  localparam logic [7:0] STX = 8'h02;
  localparam logic [7:0] ETX = 8'h03;
  localparam logic [7:0] EOT = 8'h04;
  localparam logic [7:0] STAR = 8'h2a;
  localparam logic [7:0] ASC_ZERO = 8'h30;
  localparam logic [7:0] HEX_LTR = 8'h37;
  localparam logic [7:0] CODE_OK = 8'h41;
  localparam logic [7:0] CODE_OK_ALM = 8'h61;
  localparam logic [7:0] LOWER_BASE = 8'h61;

  localparam int DATA_MAX = 16;
  localparam logic [4:0] HDR_LEN = 5'h07;
  localparam logic [1:0] MAX_TRIES = 2'h3;

  typedef enum {
    S_WAIT, S_IDLE, S_LOAD, S_SEND, S_LISTEN, S_EOT, S_GAP
  } mstate_t;
endpackage

//--- servo_link_master.sv
// master station for the addressed ascii servo link, plus its payload fifo
// assumes one 25 MHz clock, a half-duplex driver enabled by tx_en, rxd from a pin
//
// Operation
// - master starts every exchange; the drive only answers commands
// - master baud must match the drive's configured speed
// - broadcast replies come only from station 0
// - control codes: SOH 01h, STX 02h, ETX 03h, EOT 04h
// - command, data number, value and checksum are ascii, hex upper case
// - station 0..9 sent as 30h..39h, 10..15 as A..F
// - checksum: low byte of sum after leading SOH/STX through ETX, two hex digits
// - no STX within 300 ms after sending: master sends EOT
// - master resends the message 100 ms after that EOT
// - three unanswered attempts give a time-out error
// - negative code: resend; three consecutive failures flag an error
// - parity or checksum fault in a reply: resend; three flag an error
// - master waits at least 3.5 s after power-on
// - master should first confirm the link with a harmless read
// - data field length depends on the command; no fixed length
`timescale 1ns/1ps

module char_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  // depth must be a power of two so the pointers wrap by themselves
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_t;
  fifo_t q;
  fifo_t next_q;
  logic push;
  logic pop;

  assign in_ready = q.cnt != (AW+1)'(D);
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_q = q;
    if (push) begin
      next_q.mem[q.wp] = in_data;
      next_q.wp = q.wp + 1'b1;
    end
    if (pop) begin
      next_q.rp = q.rp + 1'b1;
    end
    next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

module servo_link_master
  import servo_link_pkg::*;
#(
  parameter int T_START_CYC = START_CYC,
  parameter int T_REPLY_CYC = REPLY_CYC,
  parameter int T_RESEND_CYC = RESEND_CYC,
  parameter int T_BIT_CYC = int'(BAUD_DIV)
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // command request
  input wire logic start_valid,
  output logic start_ready,
  input wire logic [4:0] station,
  input wire logic bcast,
  input wire logic [15:0] cmd,
  input wire logic [15:0] data_no,
  input wire logic want_reply,
  // payload characters, pushed before start
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  // reply stream and result
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic done,
  output logic err_timeout,
  output logic err_comm,
  output logic alarm,
  output logic [7:0] resp_code,
  // serial line
  input wire logic rxd,
  output logic txd,
  output logic tx_en
);
  typedef struct packed {
    mstate_t st;
    logic [26:0] tmr;
    logic [1:0] tries;
    logic want;
    logic [4:0] stn;
    logic bc;
    logic [31:0][7:0] frm;
    logic [4:0] len;
    logic [4:0] idx;
    logic [7:0] sum;
    logic tx_busy;
    logic [9:0] tx_sh;
    logic [3:0] tx_bit;
    logic [11:0] tx_cnt;
    logic txd;
    logic rx_s1;
    logic rx_s2;
    logic rx_busy;
    logic [3:0] rx_bit;
    logic [11:0] rx_cnt;
    logic [9:0] rx_sh;
    logic [2:0] pos;
    logic [7:0] rsum;
    logic rbad;
    logic [7:0] rhi;
    logic done;
    logic e_tmo;
    logic e_com;
    logic alarm;
    logic [7:0] code;
    logic rv;
    logic [7:0] rd;
  } master_t;
  master_t q;
  master_t d;
  // one bit time; hardware keeps the 9600 baud default, a bench may shorten it
  localparam logic [11:0] BIT_DIV = 12'(T_BIT_CYC);
  localparam logic [11:0] RX_MID = 12'(T_BIT_CYC + T_BIT_CYC / 2);

  logic f_valid;
  logic f_pop;
  logic [7:0] f_data;

  function automatic logic [7:0] hex_chr(input logic [3:0] v);
    return (v < 4'ha) ? ASC_ZERO + {4'h0, v} : HEX_LTR + {4'h0, v};
  endfunction

  function automatic logic [7:0] stn_chr(input logic [4:0] s);
    return (s < 5'h0a) ? ASC_ZERO + {3'h0, s} : HEX_LTR + {3'h0, s};
  endfunction

  char_fifo #(.W(8), .D(DATA_MAX)) payload (
    .mclk(mclk),
    .rst(rst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  assign start_ready = q.st == S_IDLE;
  assign txd = q.txd;
  assign tx_en = q.tx_busy;
  assign resp_valid = q.rv;
  assign resp_data = q.rd;
  assign done = q.done;
  assign err_timeout = q.e_tmo;
  assign err_comm = q.e_com;
  assign alarm = q.alarm;
  assign resp_code = q.code;

  logic tx_go;
  logic [7:0] tx_byte;
  logic rx_stb;
  logic rx_perr;
  logic [9:0] rx_new;
  logic [7:0] rx_byte;
  logic [7:0] s;
  logic bad;

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.rv = 1'b0;
    tx_go = 1'b0;
    tx_byte = 8'h00;
    f_pop = 1'b0;
    s = 8'h00;
    bad = 1'b0;
    // receiver: first sync stage only feeds the second
    d.rx_s1 = rxd;
    d.rx_s2 = q.rx_s1;
    rx_stb = 1'b0;
    rx_new = {q.rx_s2, q.rx_sh[9:1]};
    rx_byte = rx_new[7:0];
    rx_perr = (rx_new[8] != ^rx_new[7:0]) || !rx_new[9];
    if (!q.rx_busy) begin
      if (!q.rx_s2) begin
        d.rx_busy = 1'b1;
        d.rx_cnt = RX_MID;
        d.rx_bit = 4'h0;
      end
    end else if (q.rx_cnt == 12'h000) begin
      d.rx_sh = rx_new;
      d.rx_cnt = BIT_DIV - 12'h001;
      d.rx_bit = q.rx_bit + 4'h1;
      if (q.rx_bit == RX_BITS) begin
        d.rx_busy = 1'b0;
        rx_stb = 1'b1;
      end
    end else begin
      d.rx_cnt = q.rx_cnt - 12'h001;
    end
    // transmitter: start bit goes out on load, then data, parity, stop
    if (q.tx_busy) begin
      if (q.tx_cnt == 12'h000) begin
        d.tx_cnt = BIT_DIV - 12'h001;
        d.tx_bit = q.tx_bit + 4'h1;
        if (q.tx_bit == TX_BITS) begin
          d.tx_busy = 1'b0;
        end else begin
          d.txd = q.tx_sh[0];
          d.tx_sh = {1'b1, q.tx_sh[9:1]};
        end
      end else begin
        d.tx_cnt = q.tx_cnt - 12'h001;
      end
    end
    case (q.st)
      S_WAIT: begin
        d.tmr = q.tmr + 27'h1;
        if (q.tmr == 27'(T_START_CYC - 1)) begin
          d.st = S_IDLE;
          d.tmr = '0;
        end
      end
      S_IDLE: begin
        if (start_valid) begin
          d.frm[0] = SOH;
          d.frm[1] = bcast ? STAR : stn_chr(station);
          d.frm[2] = cmd[15:8];
          d.frm[3] = cmd[7:0];
          d.frm[4] = STX;
          d.frm[5] = data_no[15:8];
          d.frm[6] = data_no[7:0];
          d.sum = d.frm[1] + cmd[15:8] + cmd[7:0] + STX + data_no[15:8] + data_no[7:0];
          d.len = HDR_LEN;
          d.want = want_reply;
          d.stn = station;
          d.bc = bcast;
          d.tries = 2'h0;
          d.st = S_LOAD;
        end
      end
      S_LOAD: begin
        // payload length is whatever the fifo holds, up to its depth
        if (f_valid && q.len < HDR_LEN + 5'(DATA_MAX)) begin
          f_pop = 1'b1;
          d.frm[q.len] = f_data;
          d.sum = q.sum + f_data;
          d.len = q.len + 5'h01;
        end else begin
          s = q.sum + ETX;
          d.frm[q.len] = ETX;
          d.frm[5'(q.len + 5'h01)] = hex_chr(s[7:4]);
          d.frm[5'(q.len + 5'h02)] = hex_chr(s[3:0]);
          d.len = q.len + 5'h03;
          d.idx = 5'h00;
          d.st = S_SEND;
        end
      end
      S_SEND: begin
        if (!q.tx_busy) begin
          if (q.idx == q.len) begin
            d.tmr = '0;
            d.pos = 3'h0;
            if (q.want) begin
              d.st = S_LISTEN;
            end else begin
              d.done = 1'b1;
              d.e_tmo = 1'b0;
              d.e_com = 1'b0;
              d.st = S_IDLE;
            end
          end else begin
            tx_go = 1'b1;
            tx_byte = q.frm[q.idx];
            d.idx = q.idx + 5'h01;
          end
        end
      end
      S_LISTEN: begin
        d.tmr = q.tmr + 27'h1;
        if (rx_stb) begin
          // any character restarts the silence timer
          d.tmr = '0;
          d.rbad = q.rbad || rx_perr;
          d.rsum = q.rsum + rx_byte;
          case (q.pos)
            3'h0: begin
              if (rx_byte == STX) begin
                d.pos = 3'h1;
                d.rsum = 8'h00;
                d.rbad = rx_perr;
              end
            end
            3'h1: begin
              // a broadcast is answered by station 0 only
              if (rx_byte != stn_chr(q.bc ? 5'h00 : q.stn)) begin
                d.rbad = 1'b1;
              end
              d.pos = 3'h2;
            end
            3'h2: begin
              d.code = rx_byte;
              d.alarm = rx_byte >= LOWER_BASE;
              d.pos = 3'h3;
            end
            3'h3: begin
              if (rx_byte == ETX) begin
                d.pos = 3'h4;
              end else begin
                d.rv = 1'b1;
                d.rd = rx_byte;
              end
            end
            3'h4: begin
              d.rsum = q.rsum;
              d.rhi = rx_byte;
              d.pos = 3'h5;
            end
            default: begin
              d.rsum = q.rsum;
              bad = d.rbad || q.rhi != hex_chr(q.rsum[7:4]) || rx_byte != hex_chr(q.rsum[3:0]);
              d.pos = 3'h0;
              if (!bad && (q.code == CODE_OK || q.code == CODE_OK_ALM)) begin
                d.done = 1'b1;
                d.e_tmo = 1'b0;
                d.e_com = 1'b0;
                d.st = S_IDLE;
              end else if (q.tries == MAX_TRIES - 2'h1) begin
                d.tries = MAX_TRIES;
                d.done = 1'b1;
                d.e_tmo = 1'b0;
                d.e_com = 1'b1;
                d.st = S_IDLE;
              end else begin
                d.tries = q.tries + 2'h1;
                d.idx = 5'h00;
                d.st = S_SEND;
              end
            end
          endcase
        end else if (q.tmr == 27'(T_REPLY_CYC - 1)) begin
          d.tries = q.tries + 2'h1;
          d.idx = 5'h00;
          d.st = S_EOT;
        end
      end
      S_EOT: begin
        if (!q.tx_busy) begin
          if (q.idx == 5'h00) begin
            tx_go = 1'b1;
            tx_byte = EOT;
            d.idx = 5'h01;
          end else if (q.tries == MAX_TRIES) begin
            d.done = 1'b1;
            d.e_tmo = 1'b1;
            d.e_com = 1'b0;
            d.st = S_IDLE;
          end else begin
            d.tmr = '0;
            d.st = S_GAP;
          end
        end
      end
      S_GAP: begin
        d.tmr = q.tmr + 27'h1;
        if (q.tmr == 27'(T_RESEND_CYC - 1)) begin
          d.tmr = '0;
          d.idx = 5'h00;
          d.st = S_SEND;
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    if (tx_go) begin
      d.tx_busy = 1'b1;
      d.txd = 1'b0;
      d.tx_sh = {1'b1, ^tx_byte, tx_byte};
      d.tx_cnt = BIT_DIV - 12'h001;
      d.tx_bit = 4'h0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.txd <= 1'b1;
      q.rx_s1 <= 1'b1;
      q.rx_s2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  a_tx_parity: assert property (@(posedge mclk) disable iff (rst)
    $rose(q.tx_busy) |-> !q.txd && q.tx_sh[9] && q.tx_sh[8] == ^q.tx_sh[7:0])
    else $error("character framing or parity wrong");
  a_start_wait: assert property (@(posedge mclk) disable iff (rst)
    q.st == S_WAIT |-> !start_ready && !tx_en)
    else $error("link used during start-up wait");
  a_eot_code: assert property (@(posedge mclk) disable iff (rst)
    (q.st == S_EOT && tx_go) |=> q.tx_sh[7:0] == EOT && q.tx_busy)
    else $error("time-out did not send EOT");
  a_reply_tmo: assert property (@(posedge mclk) disable iff (rst)
    (q.st == S_LISTEN && d.st == S_EOT) |-> q.tmr == 27'(T_REPLY_CYC - 1))
    else $error("reply time-out at wrong count");
  a_resend_gap: assert property (@(posedge mclk) disable iff (rst)
    (q.st == S_GAP && d.st == S_SEND) |-> q.tmr == 27'(T_RESEND_CYC - 1))
    else $error("resend gap at wrong count");
  a_tries_max: assert property (@(posedge mclk) disable iff (rst)
    (q.done && (q.e_tmo || q.e_com)) |-> q.tries == MAX_TRIES)
    else $error("error flagged before third attempt");
  a_station_chr: assert property (@(posedge mclk) disable iff (rst)
    (start_valid && start_ready && !bcast) |=> q.frm[1] == stn_chr($past(station)) && q.frm[0] == SOH)
    else $error("station character wrong");
  a_only_cmd: assert property (@(posedge mclk) disable iff (rst)
    tx_en |-> q.st == S_SEND || q.st == S_EOT)
    else $error("line driven outside a command");
endmodule

//--- servo_drive_model.sv
// behavioural drive station on the far side of the serial line
// assumes the 8e1 timing and control codes of servo_link_pkg and one mclk
`timescale 1ns/1ps
module servo_drive_model
  import servo_link_pkg::*;
#(
  parameter int STN = 0,
  parameter int INIT = 40,
  // bit time and slow-reply delay in mclk cycles; a bench may shorten both
  parameter int BT = int'(BAUD_DIV),
  parameter int DLY = 20000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // settings and condition
  input wire logic dly_sel,
  input wire logic alm,
  // serial line
  input wire logic txd,
  input wire logic tx_en,
  output logic rxd
);
  // reply per attempt, queued by the bench: 00 stays silent, ff spoils the checksum
  logic [7:0] codes[$];
  logic [7:0] fr[$];
  int n_eot = 0;
  int n_fr = 0;
  int up = 0;
  logic dly_q = 1'b0;

  // settings only take hold across a reset
  always @(posedge mclk) if (rst) dly_q <= dly_sel;
  always @(posedge mclk) up <= rst ? 0 : up + 1;

  function automatic logic [7:0] hx(input logic [4:0] n);
    return n < 10 ? ASC_ZERO + 8'(n) : HEX_LTR + 8'(n);
  endfunction

  task automatic get(output logic [7:0] c, output logic ok);
    logic p;
    do @(posedge mclk); while (!(tx_en && txd === 1'b0));
    repeat (BT / 2) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      repeat (BT) @(posedge mclk);
      if (i < 8) c[i] = txd;
      else p = txd;
    end
    repeat (BT) @(posedge mclk);
    ok = (p == ^c) && txd;
  endtask

  // stop bit cut to three quarters: still seen by the stop sample, yet an instant resend is caught
  task automatic put(input logic [7:0] c);
    logic [10:0] f;
    f = {1'b1, ^c, c, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (i == 10 ? BT * 3 / 4 : BT) @(posedge mclk);
    end
  endtask

  initial begin
    logic [7:0] c, st, code, sum;
    logic [7:0] body[$];
    logic ok, pe;
    rxd = 1'b1;
    forever begin
      get(c, ok);
      if (c == EOT) n_eot++;
      if (c == SOH) begin
        fr = {c};
        pe = !ok;
        do begin
          get(c, ok);
          pe |= !ok;
          fr.push_back(c);
        end while (c != ETX && fr.size() < 40);
        get(c, ok);
        fr.push_back(c);
        get(c, ok);
        fr.push_back(c);
        n_fr++;
        sum = 8'h00;
        for (int i = 1; i < fr.size() - 2; i++) sum += fr[i];
        st = fr[1];
        // silent unless initialised and addressed; broadcasts answered by station 0 only
        if (up > INIT && (st == hx(5'(STN)) || (st == STAR && STN == 0))) begin
          code = codes.size() > 0 ? codes.pop_front() : (alm ? CODE_OK_ALM : CODE_OK);
          if (pe) code = 8'h42;
          else if (fr[fr.size() - 2] != hx(5'(sum[7:4])) || fr[fr.size() - 1] != hx(5'(sum[3:0]))) code = 8'h43;
          if (code != 8'h00) begin
            repeat (dly_q ? DLY : 2 * BT) @(posedge mclk);
            body = {st == STAR ? ASC_ZERO : st, code == 8'hff ? CODE_OK : code};
            if (code == CODE_OK || code == CODE_OK_ALM) body = {body, 8'h31, 8'h32};
            body.push_back(ETX);
            sum = code == 8'hff ? 8'h01 : 8'h00;
            foreach (body[i]) sum += body[i];
            put(STX);
            foreach (body[i]) put(body[i]);
            put(hx(5'(sum[7:4])));
            put(hx(5'(sum[3:0])));
          end
        end
      end
    end
  end
endmodule

//--- tb_servo_link_master.sv
// self-checking bench: servo_link_master against a behavioural drive station
// assumes the design files and servo_drive_model.sv compiled before it
`timescale 1ns/1ps
module tb_servo_link_master;
  import servo_link_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic start_valid = 1'b0;
  logic bcast = 1'b0;
  logic want_reply = 1'b0;
  logic in_valid = 1'b0;
  logic dly_sel = 1'b1;
  logic alm = 1'b0;
  logic done_d = 1'b0;
  logic [4:0] station = 5'h00;
  logic [15:0] cmd = 16'h3030;
  logic [15:0] data_no = 16'h3030;
  logic [7:0] in_data = 8'h30;
  logic start_ready, in_ready, resp_valid, done, err_timeout, err_comm, alarm, txd, tx_en, rxd;
  logic [7:0] resp_data, resp_code;
  logic [7:0] eq_c[$];
  logic [10:0] eq_o[$];
  logic [7:0] ef[$];
  int miscompares = 0;
  int n_checks = 0;
  int k0, k1;

  // short bit time, reply wait and slow-reply delay keep the run brief
  servo_link_master #(.T_START_CYC(50), .T_REPLY_CYC(1000), .T_RESEND_CYC(30),
                      .T_BIT_CYC(16)) i_servo_link_master (
    .mclk(mclk), .rst(rst), .start_valid(start_valid), .start_ready(start_ready), .station(station),
    .bcast(bcast), .cmd(cmd), .data_no(data_no), .want_reply(want_reply), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .resp_valid(resp_valid), .resp_data(resp_data), .done(done),
    .err_timeout(err_timeout), .err_comm(err_comm), .alarm(alarm), .resp_code(resp_code), .rxd(rxd),
    .txd(txd), .tx_en(tx_en));
  servo_drive_model #(.STN(0), .INIT(40), .BT(16), .DLY(200)) i_servo_drive_model (
    .mclk(mclk), .rst(rst), .dly_sel(dly_sel), .alm(alm), .txd(txd), .tx_en(tx_en), .rxd(rxd));

  always #20 mclk = ~mclk;

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic final_report;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [7:0] hx(input logic [4:0] n);
    return n < 10 ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction

  // outcome flags are read the cycle after done; error flags stand until the next done, alarm and resp_code until the next reply code
  always @(posedge mclk) begin
    done_d <= done;
    if (resp_valid) chk(resp_data, eq_c.size() > 0 ? eq_c.pop_front() : 8'hxx);
    if (done_d) chk({err_timeout, err_comm, alarm, resp_code}, eq_o.size() > 0 ? eq_o.pop_front() : 11'hxxx);
  end

  task automatic run(input logic [4:0] st, input logic bc, input int pl, input logic wr,
                     input logic [10:0] eo, input bit nd);
    logic [7:0] c[4];
    logic [7:0] v, sum;
    int k;
    foreach (c[i]) c[i] = hx(5'($urandom % 16));
    ef = {SOH, bc ? STAR : hx(st), c[0], c[1], STX, c[2], c[3]};
    eq_o.push_back(eo);
    if (nd) eq_c = {eq_c, 8'h31, 8'h32};
    for (int i = 0; i < pl; i++) begin
      v = hx(5'($urandom % 16));
      ef.push_back(v);
      in_valid <= 1'b1;
      in_data <= v;
      k = 0;
      do @(negedge mclk); while (in_ready !== 1'b1 && ++k < 100);
      @(posedge mclk);
    end
    in_valid <= 1'b0;
    @(negedge mclk);
    if (pl == DATA_MAX) chk(in_ready, 1'b0);
    ef.push_back(ETX);
    sum = 8'h00;
    for (int i = 1; i < ef.size(); i++) sum += ef[i];
    ef = {ef, hx(5'(sum[7:4])), hx(5'(sum[3:0]))};
    @(posedge mclk);
    start_valid <= 1'b1;
    station <= st;
    bcast <= bc;
    cmd <= {c[0], c[1]};
    data_no <= {c[2], c[3]};
    want_reply <= wr;
    k = 0;
    do @(negedge mclk); while (start_ready !== 1'b1 && ++k < 20000);
    @(posedge mclk);
    start_valid <= 1'b0;
    k = 0;
    do @(negedge mclk); while (done !== 1'b1 && ++k < 50000);
    chk(done, 1'b1);
    repeat (2) @(posedge mclk);
    chk(16'(i_servo_drive_model.fr.size()), 16'(ef.size()));
    foreach (ef[i]) chk(i_servo_drive_model.fr[i], ef[i]);
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    final_report;
  end

  initial begin
    void'($urandom(32'h2c912fe6));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    // fifo filled until it refuses, slow reply setting; first exchange is a harmless read
    run(5'h00, 1'b0, 16, 1'b1, {3'b000, CODE_OK}, 1);
    alm <= 1'b1;
    @(negedge mclk);
    chk(in_ready, 1'b1);
    @(posedge mclk);
    run(5'($urandom), 1'b1, $urandom % 8, 1'b1, {3'b001, CODE_OK_ALM}, 1);
    alm <= 1'b0;
    i_servo_drive_model.codes = {8'h45, 8'hff};
    // the spoiled-checksum attempt streams no data characters, so one extra pair stays queued
    eq_c = {8'h31, 8'h32};
    run(5'h00, 1'b0, 2, 1'b1, {3'b000, CODE_OK}, 1);
    i_servo_drive_model.codes = {8'h63, 8'h44, 8'h66};
    run(5'h00, 1'b0, 1, 1'b1, {3'b011, 8'h66}, 0);
    k0 = i_servo_drive_model.n_eot;
    k1 = i_servo_drive_model.n_fr;
    run(5'h1a, 1'b0, 1, 1'b1, {3'b101, 8'h66}, 0);
    chk(16'(i_servo_drive_model.n_eot - k0), 16'h0003);
    chk(16'(i_servo_drive_model.n_fr - k1), 16'h0003);
    run(5'h0c, 1'b0, 0, 1'b0, {3'b001, 8'h66}, 0);
    final_report;
  end
endmodule
